// ### verilog/ssdl_pkg.sv
package ssdl_pkg;

    // Chain geometry
    localparam int unsigned STAGES      = 1024;
    localparam int unsigned FIFO_DEPTH  = 32;
    localparam int unsigned FIFO_WIDTH  = 1;

    // Select level that picks the first data input
    localparam logic        SEL_FIRST   = 1'b1;

    // Reset values of the pin-facing flops
    localparam logic        RST_OUT     = 1'b0;
    localparam logic        RST_FLAG    = 1'b0;
    localparam logic [3:0]  RST_PINS    = 4'h0;

    // Pin samples travelling together through the synchroniser
    typedef struct packed {
        logic shift_clk;
        logic select;
        logic first_data_input;
        logic second_data_input;
    } ssdl_pins_t;

    // Shift engine states, one-hot
    typedef enum logic [1:0] {
        SSDL_IDLE  = 2'b01,
        SSDL_SHIFT = 2'b10
    } ssdl_state_t;

endpackage

// ### verilog/ssdl_sync.sv
`timescale 1ns/100ps

module ssdl_sync #(
    parameter int unsigned WIDTH = 4
) (
    input  wire logic             CLK,
    input  wire logic             RESET_N,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;

    // Two flops; the first feeds only the second
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            stage1   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule // ssdl_sync

// ### verilog/ssdl_fifo.sv
`timescale 1ns/100ps

module ssdl_fifo #(
    parameter int unsigned WIDTH = 1,
    parameter int unsigned DEPTH = 32
) (
    input  wire logic             CLK,
    input  wire logic             RESET_N,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);

    localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [AW:0]   FULL = (AW + 1)'(DEPTH);

    generate
        if (DEPTH < 2 || WIDTH < 1) begin : g_bad
            $error("ssdl_fifo needs DEPTH >= 2 and WIDTH >= 1");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;

    wire push = in_valid & in_ready;
    wire pop  = out_valid & out_ready;

    // Honest flags from the fill count
    assign in_ready  = (count != FULL);
    assign out_valid = (count != '0);
    assign out_data  = mem[rd_ptr];

    // Storage, written only on accepted words
    always_ff @(posedge CLK) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == LAST) ? '0 : AW'(wr_ptr + 1'b1);
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == LAST) ? '0 : AW'(rd_ptr + 1'b1);
            end
            count <= (AW + 1)'(count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
        end
    end

endmodule // ssdl_fifo

// ### verilog/ssdl_top.sv
`timescale 1ns/100ps

module ssdl_top #(
    parameter int unsigned STAGES     = ssdl_pkg::STAGES,
    parameter int unsigned FIFO_DEPTH = ssdl_pkg::FIFO_DEPTH,
    parameter logic        SEL_FIRST  = ssdl_pkg::SEL_FIRST
) (
    input  wire logic CLK,
    input  wire logic RESET_N,
    input  wire logic SHIFT_CLK,
    input  wire logic SELECT,
    input  wire logic FIRST_DATA_INPUT,
    input  wire logic SECOND_DATA_INPUT,
    output logic      DATA_OUT,
    output logic      SHIFT_READY,
    output logic      OVERRUN
);

    // Stages kept in the ring; the output flop is the last stage
    localparam int unsigned RING = STAGES - 1;
    localparam int unsigned PW   = (RING > 1) ? $clog2(RING) : 1;
    localparam logic [PW-1:0] LAST = PW'(RING - 1);

    generate
        if (STAGES < 3) begin : g_bad
            $error("ssdl_top needs STAGES >= 3");
        end
    endgenerate

    // Ring position advance with wrap
    function automatic logic [PW-1:0] ring_next(input logic [PW-1:0] p);
        ring_next = (p == LAST) ? '0 : PW'(p + 1'b1);
    endfunction

    ssdl_pkg::ssdl_pins_t pins_raw;
    ssdl_pkg::ssdl_pins_t pins_s;
    ssdl_pkg::ssdl_state_t state;
    ssdl_pkg::ssdl_state_t next_state;

    logic          clk_prev;
    logic          master_bit;
    logic          shift_bit;
    logic [PW-1:0] ptr;
    logic          ring [RING];
    logic          push_ready;
    logic          pop_valid;
    logic          pop_data;

    // Pin bundle into the synchroniser
    assign pins_raw = '{
        shift_clk:         SHIFT_CLK,
        select:            SELECT,
        first_data_input:  FIRST_DATA_INPUT,
        second_data_input: SECOND_DATA_INPUT
    };

    ssdl_sync #(
        .WIDTH    ($bits(ssdl_pkg::ssdl_pins_t))
    ) u_sync (
        .CLK      (CLK),
        .RESET_N  (RESET_N),
        .async_in (pins_raw),
        .sync_out (pins_s)
    );

    // Edge and selector decode
    wire clk_fall = clk_prev & ~pins_s.shift_clk;
    wire sel_bit  = (pins_s.select == SEL_FIRST) ?
                    pins_s.first_data_input : pins_s.second_data_input;
    wire engine_idle = (state == ssdl_pkg::SSDL_IDLE);
    wire pop_take    = engine_idle & pop_valid;
    wire do_shift = (state == ssdl_pkg::SSDL_SHIFT);

    // Edge history of the shift clock
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            clk_prev <= 1'b0;
        end else begin
            clk_prev <= pins_s.shift_clk;
        end
    end

    // Master follows the selector while clock high, frozen while low
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            master_bit <= 1'b0;
        end else if (pins_s.shift_clk) begin
            master_bit <= sel_bit;
        end
    end

    // Captured bits queue on the falling edge
    ssdl_fifo #(
        .WIDTH     (ssdl_pkg::FIFO_WIDTH),
        .DEPTH     (FIFO_DEPTH)
    ) u_fifo (
        .CLK       (CLK),
        .RESET_N   (RESET_N),
        .in_valid  (clk_fall),
        .in_ready  (push_ready),
        .in_data   (master_bit),
        .out_valid (pop_valid),
        .out_ready (engine_idle),
        .out_data  (pop_data)
    );

    // Engine: take a bit, then shift the ring once
    always_comb begin
        next_state = state;
        unique case (state)
            ssdl_pkg::SSDL_IDLE: begin
                if (pop_valid) begin
                    next_state = ssdl_pkg::SSDL_SHIFT;
                end
            end
            ssdl_pkg::SSDL_SHIFT: begin
                next_state = ssdl_pkg::SSDL_IDLE;
            end
            default: begin
                next_state = ssdl_pkg::SSDL_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state <= ssdl_pkg::SSDL_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Holding flop between queue and ring
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            shift_bit <= 1'b0;
        end else if (pop_take) begin
            shift_bit <= pop_data;
        end
    end

    // Ring storage; untouched unless a falling edge was queued
    always_ff @(posedge CLK) begin
        if (do_shift) begin
            ring[ptr] <= shift_bit;
        end
    end

    // Ring position and output stage
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ptr      <= '0;
            DATA_OUT <= ssdl_pkg::RST_OUT;
        end else if (do_shift) begin
            ptr      <= ring_next(ptr);
            DATA_OUT <= ring[ptr];
        end
    end

    // Queue status on the pins; overrun is sticky until reset
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            SHIFT_READY <= ssdl_pkg::RST_FLAG;
            OVERRUN     <= ssdl_pkg::RST_FLAG;
        end else begin
            SHIFT_READY <= push_ready;
            OVERRUN     <= OVERRUN | (clk_fall & ~push_ready);
        end
    end

    // Cycles the shift clock has rested low, saturating; feeds the rest check
    localparam logic [7:0] REST_SETTLE = 8'h08;
    logic [7:0]            rest_cycles;

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rest_cycles <= '0;
        end else if (pins_s.shift_clk) begin
            rest_cycles <= '0;
        end else if (rest_cycles != '1) begin
            rest_cycles <= rest_cycles + 8'h01;
        end
    end

    // Checks
    chain_len_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        ptr <= LAST)
        else $error("ring position beyond chain length");

    ring_wrap_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        do_shift && ptr == LAST |=> ptr == '0)
        else $error("ring position failed to wrap");

    out_delay_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        do_shift |=> DATA_OUT === $past(ring[ptr]) && ring[$past(ptr)] == $past(shift_bit))
        else $error("output not the bit stored one lap earlier");

    fall_only_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        $rose(pins_s.shift_clk) ##1 pins_s.shift_clk |-> !clk_fall)
        else $error("capture on a rising or high clock");

    select_take_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        pins_s.shift_clk ##1 clk_fall |-> master_bit == $past(sel_bit))
        else $error("captured bit differs from selected input");

    mux_path_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        pins_s.shift_clk && pins_s.select != SEL_FIRST |=> master_bit == $past(pins_s.second_data_input))
        else $error("second input not routed by selector");

    stop_hold_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        (!pins_s.shift_clk && !clk_fall && !pop_valid && !do_shift) [*2] |-> $stable(DATA_OUT) && $stable(ptr))
        else $error("contents moved with clock resting low");

    master_hold_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        !pins_s.shift_clk |=> $stable(master_bit))
        else $error("master changed while clock low");

    // Engine, queue, capture and rest checks
    fall_push_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        clk_fall && push_ready |=> pop_valid)
        else $error("captured bit not queued");

    fall_shift_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        clk_fall |-> ##[1:4] do_shift)
        else $error("falling edge produced no shift");

    take_shift_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        pop_take |=> do_shift)
        else $error("taken bit not shifted");

    shift_once_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        do_shift |=> !do_shift)
        else $error("ring shifted twice for one bit");

    ptr_step_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        do_shift |=> ptr == ring_next($past(ptr)))
        else $error("ring position skipped a stage");

    ptr_hold_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        !do_shift |=> $stable(ptr))
        else $error("ring position moved without a shift");

    out_hold_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        !do_shift |=> $stable(DATA_OUT))
        else $error("output moved without a shift");

    engine_onehot_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        $onehot(state))
        else $error("engine state not one-hot");

    master_track_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        pins_s.shift_clk |=> master_bit == $past(sel_bit))
        else $error("master not following selector while clock high");

    hold_load_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        pop_take |=> shift_bit == $past(pop_data))
        else $error("holding flop missed the queued bit");

    first_path_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        pins_s.shift_clk && pins_s.select == SEL_FIRST |=> master_bit == $past(pins_s.first_data_input))
        else $error("first input not routed by selector");

    ready_mirror_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        push_ready |=> SHIFT_READY)
        else $error("ready pin not following queue space");

    overrun_keep_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        OVERRUN |=> OVERRUN)
        else $error("overrun flag cleared without reset");

    idle_rest_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        engine_idle && !pop_valid |=> !do_shift)
        else $error("shift with nothing queued");

    queue_rest_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        !clk_fall && !pop_valid |=> !pop_valid)
        else $error("queue filled without a falling edge");

    long_rest_a: assert property (@(posedge CLK) disable iff (!RESET_N)
        rest_cycles > REST_SETTLE |-> $stable(DATA_OUT) && $stable(ptr))
        else $error("contents moved during a long low rest");

    // Scenario covers

    fall_seen_c: cover property (@(posedge CLK) disable iff (!RESET_N)
        clk_fall ##[1:4] do_shift);

    lap_done_c: cover property (@(posedge CLK) disable iff (!RESET_N)
        do_shift && ptr == LAST);

    recirc_c: cover property (@(posedge CLK) disable iff (!RESET_N)
        clk_fall && pins_s.select != SEL_FIRST);

    overrun_c: cover property (@(posedge CLK) disable iff (!RESET_N)
        clk_fall && !push_ready);

    write_c: cover property (@(posedge CLK) disable iff (!RESET_N)
        clk_fall && pins_s.select == SEL_FIRST);

endmodule // ssdl_top

// ### dv/ssdl_host_model.sv
`timescale 1ns/100ps

// Host logic that clocks the shift register and feeds its two data pins
module ssdl_host_model (
    input  wire logic CLK,
    input  wire logic DATA_OUT,
    output logic      SHIFT_CLK,
    output logic      SELECT,
    output logic      FIRST_DATA_INPUT,
    output logic      SECOND_DATA_INPUT
);
    logic recirc;
    logic second_val;

    // Loop the output back when recirculating
    assign SECOND_DATA_INPUT = recirc ? DATA_OUT : second_val;

    // Idle: clock parked low, which the device tolerates forever
    initial begin
        SHIFT_CLK = 1'b0;
        SELECT = 1'b0;
        FIRST_DATA_INPUT = 1'b0;
        second_val = 1'b0;
        recirc = 1'b0;
    end

    // One shift clock period of 25 cycles, 200 ns: 5.0 MHz at most
    task automatic pulse(input logic sel, input logic d1, input logic d2, input logic rc, input logic flip);
        @(negedge CLK);
        SELECT = sel;
        FIRST_DATA_INPUT = flip ? ~d1 : d1;
        second_val = flip ? ~d2 : d2;
        recirc = rc;
        repeat (4) @(negedge CLK);
        SHIFT_CLK = 1'b1;                     // Short high time
        repeat (4) @(negedge CLK);
        FIRST_DATA_INPUT = d1;                // Late change while high
        second_val = d2;
        repeat (4) @(negedge CLK);
        SHIFT_CLK = 1'b0;                     // Falling edge shifts
        repeat (12) @(negedge CLK);
    endtask
endmodule // ssdl_host_model

// ### dv/testbench.sv
`timescale 1ns/100ps

`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin mismatches++; \
    $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end

module testbench;
    localparam int ST = 8;

    logic CLK = 1'b0;
    logic RESET_N = 1'b0;
    logic SHIFT_CLK, SELECT, FIRST_DATA_INPUT, SECOND_DATA_INPUT;
    logic DATA_OUT, SHIFT_READY, OVERRUN;
    int   mismatches = 0;
    int   n_compared = 0;
    int   n_shift = 0;
    logic hist [0:255];
    logic held;

    // 125 MHz system clock
    always #4 CLK = ~CLK;

    ssdl_top #(.STAGES(ST)) i_dut (
        .CLK(CLK), .RESET_N(RESET_N), .SHIFT_CLK(SHIFT_CLK), .SELECT(SELECT),
        .FIRST_DATA_INPUT(FIRST_DATA_INPUT), .SECOND_DATA_INPUT(SECOND_DATA_INPUT),
        .DATA_OUT(DATA_OUT), .SHIFT_READY(SHIFT_READY), .OVERRUN(OVERRUN)
    );

    ssdl_host_model i_host (
        .CLK(CLK), .DATA_OUT(DATA_OUT), .SHIFT_CLK(SHIFT_CLK), .SELECT(SELECT),
        .FIRST_DATA_INPUT(FIRST_DATA_INPUT), .SECOND_DATA_INPUT(SECOND_DATA_INPUT)
    );

    // One shift with its expected capture; output checked STAGES-1 shifts on
    task automatic step(input logic sel, input logic d1, input logic d2, input logic rc, input logic flip);
        logic cap;
        cap = (sel === ssdl_pkg::SEL_FIRST) ? d1 : (rc ? DATA_OUT : d2);
        i_host.pulse(sel, d1, d2, rc, flip);
        hist[n_shift] = cap;
        if (n_shift >= ST - 1) `CHK(DATA_OUT, hist[n_shift - ST + 1])
        n_shift++;
    endtask

    // Reset values, then ready once released
    task automatic test_reset;
        repeat (12) @(negedge CLK);
        `CHK(DATA_OUT, ssdl_pkg::RST_OUT)
        `CHK(SHIFT_READY, 1'b0)
        RESET_N = 1'b1;
        repeat (3) @(negedge CLK);
        `CHK(SHIFT_READY, 1'b1)
        `CHK(OVERRUN, ssdl_pkg::RST_FLAG)
        $display("test_reset done");
    endtask

    // Pattern through the first input, delay of STAGES-1 shifts
    task automatic test_write;
        logic [15:0] pat;
        pat = 16'hB35C;
        for (int i = 0; i < 16; i++) begin
            step(ssdl_pkg::SEL_FIRST, pat[i], ~pat[i], 1'b0, 1'b0);
        end
        $display("test_write done");
    endtask

    // Alternate select with differing inputs, late data change while high
    task automatic test_select;
        logic [15:0] pat;
        pat = 16'h6A93;
        for (int i = 0; i < 16; i++) begin
            step(i[0], pat[i], ~pat[i], 1'b0, i[1]);
        end
        $display("test_select done");
    endtask

    // Output fed back on the second input: contents keep circulating
    task automatic test_recirc;
        for (int i = 0; i < 24; i++) begin
            step(~ssdl_pkg::SEL_FIRST, 1'b1, 1'b0, 1'b1, 1'b0);
        end
        $display("test_recirc done");
    endtask

    // Clock parked low: output and status stay put
    task automatic test_hold;
        held = DATA_OUT;
        repeat (300) @(negedge CLK);
        `CHK(DATA_OUT, held)
        `CHK(OVERRUN, 1'b0)
        `CHK(SHIFT_READY, 1'b1)
        step(ssdl_pkg::SEL_FIRST, 1'b0, 1'b1, 1'b0, 1'b0);
        $display("test_hold done");
    endtask

    // Counts and verdict, then stop
    task automatic print_verdict;
        $display("compared %0d, mismatched %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        test_reset();
        test_write();
        test_select();
        test_recirc();
        test_hold();
        print_verdict();
    end

    // Watchdog, well past the expected 1740 cycles
    initial begin
        repeat (20000) @(posedge CLK);
        mismatches++;
        print_verdict();
    end
endmodule // testbench
